//--- src/adc_sequence_buffer_control.sv
`timescale 1ns/1ps
// Operation
// - reference select 000/1xx supply-ground, 001 ext high, 010 ext low, 011 both external
// - scan enable steps the channel 0 positive input each sample, else no scan
// - channel count 00 converts ch0, 01 ch0-1, 1x ch0-3
// - in twelve-bit mode channel count reads zero, only channel 0 converts
// - half status reads 1 filling second half, 0 first half, split mode only
// - without DMA, interrupt after every (code+1)th conversion
// - with DMA, advance DMA address after every (code+1)th conversion
// - with DMA enabled every result lands in the first result word
// - with DMA disabled each group fills result words upward from word 0, or from word 8 in the second split half
// - DMA words per input is two to the power of the code
// - unimplemented bits read zero, fields reset to zero, writes there ignored
module adc_sequence_buffer_control (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        srst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // converter results
   input  wire logic        convDone,
   input  wire logic [15:0] convResult,
   // converter configuration
   output logic             refHighExternal,
   output logic             refLowExternal,
   output logic      [1:0]  channelCount,
   output logic             twelveBitMode,
   output logic             alternateInputSampling,
   output logic             scanActive,
   output logic      [3:0]  scanInputIndex,
   // dma side
   output logic             dmaRequest,
   output logic             dmaAddressAdvance,
   output logic      [7:0]  dmaWordsPerInput,
   // interrupt
   output logic             irq
);
   import asb_pkg::*;

   asb_conv_if cv ();

   // software-visible fields
   logic [2:0]  referenceSelect;
   logic        channel0ScanEnable;
   logic [1:0]  channelCountSelect;
   logic [3:0]  samplesPerEvent;
   logic        splitBufferMode;
   logic        dmaResultEnable;
   logic [2:0]  dmaWordsCode;
   logic [1:0]  intStatus;
   logic [1:0]  intMask;

   logic        accessEnd;
   logic        writeEnd;
   logic        readEnd;
   logic        hitControlTwo;
   logic        hitControlFour;
   logic        hitStatus;
   logic        hitMask;
   logic        hitMode;
   logic        hitResult;
   logic        mapped;
   logic [31:0] next_prdata;
   logic [1:0]  intSet;
   logic [1:0]  intClear;

   // one wait state: pready rises on the second access cycle
   assign accessEnd = psel && penable && pready;
   assign writeEnd  = accessEnd && pwrite;
   assign readEnd   = accessEnd && !pwrite;

   assign hitControlTwo  = (paddr == ADDR_CONTROL_TWO);
   assign hitControlFour = (paddr == ADDR_CONTROL_FOUR);
   assign hitStatus      = (paddr == ADDR_INT_STATUS);
   assign hitMask        = (paddr == ADDR_INT_MASK);
   assign hitMode        = (paddr == ADDR_MODE);
   assign hitResult      = (paddr >= ADDR_RESULT_BASE) && (paddr <= ADDR_RESULT_LAST)
                           && (paddr[1:0] == 2'h0);
   assign mapped         = hitControlTwo | hitControlFour | hitStatus | hitMask
                           | hitMode | hitResult;

   // wiring of the shared conversion bundle
   assign cv.convDone        = convDone;
   assign cv.convResult      = convResult;
   assign cv.samplesPerEvent = samplesPerEvent;
   assign cv.dmaResultEnable = dmaResultEnable;
   assign cv.splitBufferMode = splitBufferMode;
   assign cv.rdIndex         = paddr[5:2];
   // any write to a configuration register restarts the group count
   assign cv.restart         = writeEnd && (hitControlTwo | hitControlFour | hitMode);

   asb_event_counter u_counter (
      .sys_clk (sys_clk),
      .srst    (srst),
      .cv      (cv)
   );

   asb_result_buffer u_buffer (
      .sys_clk (sys_clk),
      .srst    (srst),
      .cv      (cv)
   );

   // apb handshake; every access answers, unmapped ones with pslverr
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
      end
   end

   // read mux; unimplemented bits stay zero
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (hitControlTwo) begin
         next_prdata[REF_SEL_LSB +: 3]  = referenceSelect;
         next_prdata[SCAN_EN_BIT]       = channel0ScanEnable;
         next_prdata[CHAN_CNT_LSB +: 2] = effChannelCount(channelCountSelect,
                                                          twelveBitMode);
         next_prdata[HALF_STAT_BIT]     = cv.bufferHalfStatus;
         next_prdata[SMP_EVT_LSB +: 4]  = samplesPerEvent;
         next_prdata[SPLIT_BIT]         = splitBufferMode;
         next_prdata[ALT_BIT]           = alternateInputSampling;
      end else if (hitControlFour) begin
         next_prdata[DMA_EN_BIT]        = dmaResultEnable;
         next_prdata[DMA_WPI_LSB +: 3]  = dmaWordsCode;
      end else if (hitStatus) begin
         next_prdata[1:0]               = intStatus;
      end else if (hitMask) begin
         next_prdata[1:0]               = intMask;
      end else if (hitMode) begin
         next_prdata[TWELVE_BIT]        = twelveBitMode;
      end else if (hitResult) begin
         next_prdata[15:0]              = cv.rdData;
      end
   end

   // read data is latched as pready rises and held until the next read answer
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready && !pwrite) begin
         prdata <= next_prdata;
      end
   end

   // control two: only implemented fields store, half status is read-only
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         referenceSelect        <= RESET_REF_SEL;
         channel0ScanEnable     <= 1'b0;
         channelCountSelect     <= RESET_CHAN_CNT;
         samplesPerEvent        <= RESET_SMP_EVT;
         splitBufferMode        <= 1'b0;
         alternateInputSampling <= 1'b0;
      end else if (writeEnd && hitControlTwo) begin
         referenceSelect        <= pwdata[REF_SEL_LSB +: 3];
         channel0ScanEnable     <= pwdata[SCAN_EN_BIT];
         // the field does not exist in twelve-bit mode, so writes load the reset value instead
         channelCountSelect     <= twelveBitMode ? RESET_CHAN_CNT
                                                 : pwdata[CHAN_CNT_LSB +: 2];
         samplesPerEvent        <= pwdata[SMP_EVT_LSB +: 4];
         splitBufferMode        <= pwdata[SPLIT_BIT];
         alternateInputSampling <= pwdata[ALT_BIT];
      end
   end

   // control four and mode register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dmaResultEnable <= 1'b0;
         dmaWordsCode    <= RESET_DMA_WPI;
         twelveBitMode   <= 1'b0;
      end else begin
         if (writeEnd && hitControlFour) begin
            dmaResultEnable <= pwdata[DMA_EN_BIT];
            dmaWordsCode    <= pwdata[DMA_WPI_LSB +: 3];
         end
         if (writeEnd && hitMode) begin
            twelveBitMode <= pwdata[TWELVE_BIT];
         end
      end
   end

   // converter configuration outputs, registered
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         refHighExternal  <= 1'b0;
         refLowExternal   <= 1'b0;
         channelCount     <= RESET_CHAN_CNT;
         dmaWordsPerInput <= 8'h01;
      end else begin
         // any 1xx code falls back to supply and ground
         refHighExternal  <= (referenceSelect == REF_EXTH_GND)
                             || (referenceSelect == REF_EXTH_EXTL);
         refLowExternal   <= (referenceSelect == REF_SUPPLY_EXTL)
                             || (referenceSelect == REF_EXTH_EXTL);
         channelCount     <= effChannelCount(channelCountSelect, twelveBitMode);
         dmaWordsPerInput <= wordsPerInput(dmaWordsCode);
      end
   end

   // channel 0 positive input scan steps once per completed sample
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         scanActive     <= 1'b0;
         scanInputIndex <= 4'h0;
      end else begin
         scanActive <= channel0ScanEnable;
         if (!channel0ScanEnable) begin
            scanInputIndex <= 4'h0;
         end else if (convDone) begin
            scanInputIndex <= scanInputIndex + 4'h1;
         end
      end
   end

   // dma strobes: a request per result, an address step per group
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dmaRequest        <= 1'b0;
         dmaAddressAdvance <= 1'b0;
      end else begin
         dmaRequest        <= convDone && dmaResultEnable;
         dmaAddressAdvance <= cv.groupEnd && dmaResultEnable;
      end
   end

   // sticky status; a new event in the clearing read's cycle survives
   assign intSet[INT_SAMPLE]   = cv.groupEnd && !dmaResultEnable;
   assign intSet[INT_DMA_STEP] = cv.groupEnd && dmaResultEnable;
   assign intClear             = (readEnd && hitStatus) ? 2'h3 : 2'h0;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         intStatus <= RESET_INT;
      end else begin
         intStatus <= (intStatus & ~intClear) | intSet;
      end
   end

   // mask register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         intMask <= RESET_INT;
      end else if (writeEnd && hitMask) begin
         intMask <= pwdata[1:0];
      end
   end

   // level interrupt, one cycle behind the status bits
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(intStatus & intMask);
      end
   end
endmodule : adc_sequence_buffer_control

//--- common/asb_pkg.sv
package asb_pkg;
   // register byte offsets
   localparam logic [11:0] ADDR_CONTROL_TWO  = 12'h000;
   localparam logic [11:0] ADDR_CONTROL_FOUR = 12'h004;
   localparam logic [11:0] ADDR_INT_STATUS   = 12'h008;
   localparam logic [11:0] ADDR_INT_MASK     = 12'h00C;
   localparam logic [11:0] ADDR_MODE         = 12'h010;
   localparam logic [11:0] ADDR_RESULT_BASE  = 12'h040;
   localparam logic [11:0] ADDR_RESULT_LAST  = 12'h07C;

   // control two field positions
   localparam int REF_SEL_LSB   = 13;
   localparam int SCAN_EN_BIT   = 10;
   localparam int CHAN_CNT_LSB  = 8;
   localparam int HALF_STAT_BIT = 7;
   localparam int SMP_EVT_LSB   = 2;
   localparam int SPLIT_BIT     = 1;
   localparam int ALT_BIT       = 0;
   // control four field positions
   localparam int DMA_EN_BIT    = 8;
   localparam int DMA_WPI_LSB   = 0;
   // own mode register
   localparam int TWELVE_BIT    = 0;
   // interrupt status bits
   localparam int INT_SAMPLE    = 0;
   localparam int INT_DMA_STEP  = 1;

   // reset values
   localparam logic [2:0]  RESET_REF_SEL  = 3'h0;
   localparam logic [1:0]  RESET_CHAN_CNT = 2'h0;
   localparam logic [3:0]  RESET_SMP_EVT  = 4'h0;
   localparam logic [2:0]  RESET_DMA_WPI  = 3'h0;
   localparam logic [1:0]  RESET_INT      = 2'h0;
   localparam logic [15:0] RESET_RESULT   = 16'h0000;

   // reference codes
   localparam logic [2:0] REF_SUPPLY_GND  = 3'h0;
   localparam logic [2:0] REF_EXTH_GND    = 3'h1;
   localparam logic [2:0] REF_SUPPLY_EXTL = 3'h2;
   localparam logic [2:0] REF_EXTH_EXTL   = 3'h3;

   // channel count select as seen by the converter, forced to zero in twelve-bit mode
   function automatic logic [1:0] effChannelCount(input logic [1:0] code,
                                                  input logic       twelve);
      effChannelCount = twelve ? 2'h0 : code;
   endfunction : effChannelCount

   // words of DMA buffer per input: two to the power of the code
   function automatic logic [7:0] wordsPerInput(input logic [2:0] code);
      wordsPerInput = 8'h01 << code;
   endfunction : wordsPerInput
endpackage : asb_pkg

//--- common/asb_conv_if.sv
`timescale 1ns/1ps
interface asb_conv_if;
   logic        convDone;
   logic [15:0] convResult;
   logic [3:0]  samplesPerEvent;
   logic        dmaResultEnable;
   logic        splitBufferMode;
   logic        restart;
   logic        groupEnd;
   logic [3:0]  rdIndex;
   logic [15:0] rdData;
   logic        bufferHalfStatus;

   modport ctrl (output convDone, convResult, samplesPerEvent, dmaResultEnable,
                 splitBufferMode, restart, rdIndex,
                 input groupEnd, rdData, bufferHalfStatus);
   modport counter (input convDone, samplesPerEvent, restart, output groupEnd);
   modport buffer (input convDone, convResult, dmaResultEnable, splitBufferMode,
                   restart, groupEnd, rdIndex, output rdData, bufferHalfStatus);
endinterface : asb_conv_if

//--- src/asb_event_counter.sv
`timescale 1ns/1ps
module asb_event_counter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // conversion side
   asb_conv_if.counter cv
);
   import asb_pkg::*;

   logic [3:0] count;

   // last conversion of a group ends the group
   assign cv.groupEnd = cv.convDone && (count == cv.samplesPerEvent);

   // restart on reconfigure beats a conversion arriving in the same cycle
   always_ff @(posedge sys_clk) begin
      if (srst || cv.restart) begin
         count <= RESET_SMP_EVT;
      end else if (cv.groupEnd) begin
         count <= RESET_SMP_EVT;
      end else if (cv.convDone) begin
         count <= count + 4'h1;
      end
   end
endmodule : asb_event_counter

//--- src/asb_result_buffer.sv
`timescale 1ns/1ps
module asb_result_buffer (
   // clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // conversion side
   asb_conv_if.buffer cv
);
   import asb_pkg::*;

   logic [15:0] resultWord [16];
   logic [3:0]  fillIndex;
   logic        fillHalf;
   logic [3:0]  writeAddr;

   // dma mode funnels every result into the first word
   always_comb begin
      if (cv.dmaResultEnable) begin
         writeAddr = 4'h0;
      end else if (cv.splitBufferMode) begin
         writeAddr = {fillHalf, fillIndex[2:0]};
      end else begin
         writeAddr = fillIndex;
      end
   end

   // fill pointer returns to the start of a half at each group end
   always_ff @(posedge sys_clk) begin
      if (srst || cv.restart) begin
         fillIndex <= 4'h0;
         fillHalf  <= 1'b0;
      end else if (cv.groupEnd) begin
         fillIndex <= 4'h0;
         fillHalf  <= cv.splitBufferMode ? ~fillHalf : 1'b0;
      end else if (cv.convDone) begin
         fillIndex <= fillIndex + 4'h1;
      end
   end

   // result storage; reset clears every word so reads are defined
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         for (int i = 0; i < 16; i++) begin
            resultWord[i] <= RESET_RESULT;
         end
      end else if (cv.convDone) begin
         resultWord[writeAddr] <= cv.convResult;
      end
   end

   assign cv.rdData           = resultWord[cv.rdIndex];
   // software reads the half that is not being filled
   assign cv.bufferHalfStatus = cv.splitBufferMode & fillHalf;
endmodule : asb_result_buffer

//--- dv/asb_ctrl_sva.sv
`timescale 1ns/1ps
module asb_ctrl_sva (
   // clock and reset
   input wire logic        sys_clk,
   input wire logic        srst,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // converter, dma, interrupt
   input wire logic        convDone,
   input wire logic        refHighExternal,
   input wire logic        refLowExternal,
   input wire logic [1:0]  channelCount,
   input wire logic        twelveBitMode,
   input wire logic        scanActive,
   input wire logic [3:0]  scanInputIndex,
   input wire logic        dmaRequest,
   input wire logic        dmaAddressAdvance,
   input wire logic [7:0]  dmaWordsPerInput,
   input wire logic        irq
);
   import asb_pkg::*;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   // finished transfer, and one that wrote control two
   wire apbDone = psel && penable && pready;
   wire wrCtl2  = apbDone && pwrite && paddr == ADDR_CONTROL_TWO;
   // two edges, one for the field register and one for the registered output
   property refHigh_p;
      logic [2:0] v;
      (wrCtl2, v = pwdata[REF_SEL_LSB +: 3])
         |-> ##2 refHighExternal == (v == REF_EXTH_GND || v == REF_EXTH_EXTL);
   endproperty
   property refLow_p;
      logic [2:0] v;
      (wrCtl2, v = pwdata[REF_SEL_LSB +: 3])
         |-> ##2 refLowExternal == (v == REF_SUPPLY_EXTL || v == REF_EXTH_EXTL);
   endproperty
   refs_high_a: assert property (refHigh_p)
      else $error("high reference select wrong");
   refs_low_a: assert property (refLow_p)
      else $error("low reference select wrong");
   twelve_chan_a: assert property (twelveBitMode ##1 twelveBitMode
      |-> channelCount == 2'h0)
      else $error("channel count not zero in twelve-bit mode");
   scan_step_a: assert property (scanActive && convDone ##1 scanActive
      |-> scanInputIndex == $past(scanInputIndex) + 4'h1)
      else $error("scan index did not step");
   dma_req_a: assert property (dmaRequest |-> $past(convDone))
      else $error("dma request without conversion");
   dma_adv_a: assert property (dmaAddressAdvance |-> dmaRequest)
      else $error("address step without request");
   wpi_onehot_a: assert property ($onehot(dmaWordsPerInput))
      else $error("words per input not a power of two");
   ready_wait_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error response without ready");
   irq_cause_a: assert property ($rose(irq)
      |-> $past(convDone, 2) || $past(apbDone) || $past(apbDone, 2))
      else $error("interrupt rose without cause");
   cover property (irq);
   cover property (dmaAddressAdvance);
   cover property (pslverr);
endmodule : asb_ctrl_sva

bind adc_sequence_buffer_control asb_ctrl_sva u_sva (
   .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .convDone(convDone), .refHighExternal(refHighExternal), .refLowExternal(refLowExternal),
   .channelCount(channelCount), .twelveBitMode(twelveBitMode), .scanActive(scanActive),
   .scanInputIndex(scanInputIndex), .dmaRequest(dmaRequest),
   .dmaAddressAdvance(dmaAddressAdvance), .dmaWordsPerInput(dmaWordsPerInput), .irq(irq)
);

//--- dv/asb_conv_model.sv
`timescale 1ns/1ps
module asb_conv_model (
   // clock
   input wire logic        sys_clk,
   // converter results
   output logic            convDone,
   output logic     [15:0] convResult,
   // dma strobes
   input wire logic        dmaRequest,
   input wire logic        dmaAddressAdvance
);
   int nReq = 0;
   int nAdv = 0;
   initial begin
      convDone   = 1'b0;
      convResult = 16'h0000;
   end
   // back-to-back conversions, the hardest pace the block must take
   task automatic burst(input int n, input logic [15:0] base);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         convDone   <= 1'b1;
         convResult <= base + 16'(i);
      end
      @(posedge sys_clk);
      convDone   <= 1'b0;
      convResult <= ~convResult; // stale result must not look valid
   endtask : burst
   task automatic clear();
      nReq = 0;
      nAdv = 0;
   endtask : clear
   // dma controller side counts what it is asked to move
   always @(posedge sys_clk) begin
      if (dmaRequest === 1'b1) nReq++;
      if (dmaAddressAdvance === 1'b1) nAdv++;
   end
endmodule : asb_conv_model

//--- dv/adc_sequence_buffer_control_tb_top.sv
`timescale 1ns/1ps
module adc_sequence_buffer_control_tb_top;
   import asb_pkg::*;
   logic        sys_clk, srst, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        pready, pslverr, convDone, refHighExternal, refLowExternal, twelveBitMode;
   logic        alternateInputSampling, scanActive, dmaRequest, dmaAddressAdvance, irq;
   logic [15:0] convResult;
   logic [1:0]  channelCount;
   logic [3:0]  scanInputIndex;
   logic [7:0]  dmaWordsPerInput;
   int          n_errors = 0;
   int          checked  = 0;

   adc_sequence_buffer_control DUT (
      .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .convDone(convDone), .convResult(convResult), .refHighExternal(refHighExternal),
      .refLowExternal(refLowExternal), .channelCount(channelCount),
      .twelveBitMode(twelveBitMode), .alternateInputSampling(alternateInputSampling),
      .scanActive(scanActive), .scanInputIndex(scanInputIndex), .dmaRequest(dmaRequest),
      .dmaAddressAdvance(dmaAddressAdvance), .dmaWordsPerInput(dmaWordsPerInput), .irq(irq));
   asb_conv_model model (.sys_clk(sys_clk), .convDone(convDone), .convResult(convResult),
      .dmaRequest(dmaRequest), .dmaAddressAdvance(dmaAddressAdvance));

   always #50 sys_clk = ~sys_clk;

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // pready is sampled at the rising edge; the request stands until that edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge sys_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp,
                        input logic [31:0] m = 32'hFFFFFFFF);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(name, exp, q & m);
   endtask : rdchk
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : idle

   task automatic t_regs();
      logic [31:0] q;
      logic        e;
      chk("alt reset", 32'h0, alternateInputSampling);
      chk("twelve-bit reset", 32'h0, twelveBitMode);
      rdchk("control two", ADDR_CONTROL_TWO, 32'h0);
      rdchk("control four", ADDR_CONTROL_FOUR, 32'h0);
      chk("words per input", 32'h1, dmaWordsPerInput);
      apb(1'b0, 12'h800, 32'h0, q, e);
      chk("unmapped error", 32'h1, e);
      wr(ADDR_CONTROL_TWO, 32'hFFFFFFFF);
      rdchk("control two ones", ADDR_CONTROL_TWO, 32'h0000E73F);
      chk("alt sampling", 32'h1, alternateInputSampling);
      wr(ADDR_CONTROL_FOUR, 32'hFFFFFFFF);
      rdchk("control four ones", ADDR_CONTROL_FOUR, 32'h00000107);
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_CONTROL_FOUR, 32'(c));
         idle(2);
         chk("words per input", 32'h1 << c, dmaWordsPerInput);
         wr(ADDR_CONTROL_TWO, 32'(c) << REF_SEL_LSB);
         idle(2);
         chk("ref high", 32'(c == 1 || c == 3), refHighExternal);
         chk("ref low", 32'(c == 2 || c == 3), refLowExternal);
      end
      wr(ADDR_CONTROL_FOUR, 32'h0);
   endtask : t_regs
   task automatic t_chan();
      for (int c = 0; c < 4; c++) begin
         wr(ADDR_CONTROL_TWO, 32'(c) << CHAN_CNT_LSB);
         idle(2);
         chk("channel count", 32'(c), channelCount);
      end
      wr(ADDR_MODE, 32'h1);
      wr(ADDR_CONTROL_TWO, 32'h300);
      idle(2);
      chk("twelve-bit count", 32'h0, channelCount);
      chk("twelve-bit flag", 32'h1, twelveBitMode);
      rdchk("twelve-bit read", ADDR_CONTROL_TWO, 32'h0);
      wr(ADDR_MODE, 32'h0);
   endtask : t_chan
   task automatic t_scan();
      wr(ADDR_CONTROL_TWO, 32'h400);
      model.burst(3, 16'h0A00);
      idle(2);
      chk("scan active", 32'h1, scanActive);
      chk("scan index", 32'h3, scanInputIndex);
      wr(ADDR_CONTROL_TWO, 32'h0);
      idle(2);
      chk("scan index off", 32'h0, scanInputIndex);
      rdchk("status", ADDR_INT_STATUS, 32'h1);
   endtask : t_scan
   // reconfiguring mid-group must restart the count of four
   task automatic t_irq();
      model.clear();
      wr(ADDR_INT_MASK, 32'h1);
      wr(ADDR_CONTROL_TWO, 32'hC);
      model.burst(2, 16'h10F0);
      wr(ADDR_CONTROL_TWO, 32'hC);
      model.burst(3, 16'h1100);
      idle(3);
      chk("irq early", 32'h0, irq);
      model.burst(1, 16'h1103);
      idle(3);
      chk("irq", 32'h1, irq);
      rdchk("status", ADDR_INT_STATUS, 32'h1);
      idle(2);
      chk("irq cleared", 32'h0, irq);
      for (int k = 0; k < 4; k++) begin
         rdchk("result word", ADDR_RESULT_BASE + 12'(4 * k), 32'h1100 + k);
      end
      chk("dma requests", 32'h0, model.nReq);
      wr(ADDR_INT_MASK, 32'h0);
      wr(ADDR_CONTROL_TWO, 32'h3C);
      model.burst(15, 16'h1200);
      idle(3);
      rdchk("status at 15", ADDR_INT_STATUS, 32'h0);
      model.burst(1, 16'h120F);
      idle(3);
      chk("irq masked", 32'h0, irq);
      rdchk("status at 16", ADDR_INT_STATUS, 32'h1);
   endtask : t_irq
   task automatic t_split();
      wr(ADDR_CONTROL_TWO, 32'h6);
      rdchk("half first", ADDR_CONTROL_TWO, 32'h6);
      model.burst(2, 16'h2200);
      idle(2);
      rdchk("half second", ADDR_CONTROL_TWO, 32'h86);
      model.burst(2, 16'h2208);
      idle(2);
      rdchk("half back", ADDR_CONTROL_TWO, 32'h6);
      rdchk("word 1", ADDR_RESULT_BASE + 12'h4, 32'h2201);
      rdchk("word 8", ADDR_RESULT_BASE + 12'h20, 32'h2208);
      rdchk("word 9", ADDR_RESULT_BASE + 12'h24, 32'h2209);
      rdchk("status", ADDR_INT_STATUS, 32'h1);
   endtask : t_split
   task automatic t_dma();
      model.clear();
      wr(ADDR_CONTROL_FOUR, 32'h102);
      wr(ADDR_CONTROL_TWO, 32'h4);
      model.burst(4, 16'h3300);
      idle(3);
      chk("dma requests", 32'h4, model.nReq);
      chk("address steps", 32'h2, model.nAdv);
      chk("words per input", 32'h4, dmaWordsPerInput);
      rdchk("dma word", ADDR_RESULT_BASE, 32'h3303);
      rdchk("dma step status", ADDR_INT_STATUS, 32'h2, 32'h2);
   endtask : t_dma

   task automatic finish_test();
      if (n_errors == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      sys_clk = 1'b0;
      srst    = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_chan();
      t_scan();
      t_irq();
      t_split();
      t_dma();
      finish_test();
   end
   // a hang counts as a failure
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_errors++;
      finish_test();
   end
endmodule : adc_sequence_buffer_control_tb_top
